// file: bapwm_defines.svh
`ifndef BAPWM_DEFINES_SVH
`define BAPWM_DEFINES_SVH

`define BAPWM_OFF_CTRL 12'h000
`define BAPWM_OFF_PERIOD 12'h004
`define BAPWM_OFF_BUF0 12'h008
`define BAPWM_OFF_BUF1 12'h00C
`define BAPWM_OFF_CMP0 12'h010
`define BAPWM_OFF_CMP1 12'h014
`define BAPWM_OFF_CNT 12'h018
`define BAPWM_OFF_IRQ_STAT 12'h01C
`define BAPWM_OFF_IRQ_EN 12'h020
`define BAPWM_OFF_IRQ_CLR 12'h024

`define BAPWM_CTRL_RUN 0
`define BAPWM_CTRL_BUFMODE 1

`define BAPWM_IRQ_PERIOD 0
`define BAPWM_IRQ_LATE0 1
`define BAPWM_IRQ_LATE1 2

`define BAPWM_PERIOD_RST 16'h00FF
`define BAPWM_DUTY_RST 16'h0000

`endif

// file: bapwm_pkg.sv
package bapwm_pkg;
  typedef logic [15:0] bapwm_val_t;
  typedef logic [11:0] bapwm_addr_t;
  typedef enum logic [1:0] {BAPWM_RESP_OKAY = 2'b00, BAPWM_RESP_SLVERR = 2'b10} bapwm_resp_t;
endpackage : bapwm_pkg

// file: bapwm_channel.sv
`timescale 1ns/1ps
`include "bapwm_defines.svh"
module bapwm_channel
  import bapwm_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // Timing
  input wire bapwm_pkg::bapwm_val_t cnt,
  input wire logic period_start,
  input wire logic run,
  input wire logic buf_mode,
  // Software values
  input wire bapwm_pkg::bapwm_val_t buf_val,
  input wire logic direct_wr,
  input wire bapwm_pkg::bapwm_val_t direct_val,
  // Results
  output bapwm_pkg::bapwm_val_t compare,
  output logic late_write,
  output logic pwm
);
  bapwm_val_t next_compare;
  logic next_pwm;
  logic next_late_write;
  logic hold_high;
  logic next_hold_high;

  always_comb
  begin
    next_compare = compare;
    next_late_write = 1'b0;
    next_hold_high = hold_high;
    if (period_start || !run)
      next_hold_high = 1'b0;
    if (buf_mode)
    begin
      if (period_start)
        next_compare = buf_val;
    end
    else if (direct_wr)
    begin
      next_compare = direct_val;
      next_late_write = run && (cnt >= direct_val) && !period_start;
    end
    // A compare match missed by a late write keeps the pin high to the end of the period
    if (next_late_write)
      next_hold_high = 1'b1;
    // Output high while the counter is below the compare value
    next_pwm = run && ((cnt < compare) || hold_high);
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      compare <= `BAPWM_DUTY_RST;
      pwm <= 1'b0;
      late_write <= 1'b0;
      hold_high <= 1'b0;
    end
    else
    begin
      compare <= next_compare;
      pwm <= next_pwm;
      late_write <= next_late_write;
      hold_high <= next_hold_high;
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  property p_buf_reload;
    (buf_mode && period_start) |=> (compare == $past(buf_val));
  endproperty
  a_buf_reload: assert property (p_buf_reload) else $error("compare not reloaded at period start");
  property p_buf_hold;
    ($past(buf_mode) && !$past(period_start)) |-> $stable(compare);
  endproperty
  a_buf_hold: assert property (p_buf_hold) else $error("buffered compare changed mid period");
  property p_late_full;
    (direct_wr && !buf_mode && run && !period_start && cnt >= direct_val) |=> ##1 pwm;
  endproperty
  a_late_full: assert property (p_late_full) else $error("late write gave no full pulse");
  property p_idle_low;
    !run |=> !pwm;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("pin high while stopped");
  property p_zero_low;
    (run && !hold_high && compare == 16'h0000) |=> !pwm;
  endproperty
  a_zero_low: assert property (p_zero_low) else $error("zero duty gave a pulse");
  property p_pulse_start;
    (run && cnt == 16'h0000 && compare != 16'h0000) |=> pwm;
  endproperty
  a_pulse_start: assert property (p_pulse_start) else $error("pulse missing at period start");
endmodule : bapwm_channel

// file: bapwm_top.sv
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "bapwm_defines.svh"
module bapwm_top
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // AXI4-Lite write address
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire bapwm_pkg::bapwm_addr_t S_AXI_AWADDR,
  // AXI4-Lite write data
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  // AXI4-Lite write response
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,
  // AXI4-Lite read address
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire bapwm_pkg::bapwm_addr_t S_AXI_ARADDR,
  // AXI4-Lite read data
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  // Pins
  output logic PWM_OUT_CH0,
  output logic PWM_OUT_CH1,
  output logic IRQ
);
  import bapwm_pkg::*;

  logic aw_held, w_held;
  bapwm_addr_t aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic next_aw_held, next_w_held, next_bvalid, next_rvalid;
  bapwm_addr_t next_aw_addr;
  logic [31:0] next_w_data, next_rdata;
  logic [3:0] next_w_strb;
  logic [1:0] next_bresp, next_rresp;

  logic [1:0] ctrl, next_ctrl;
  bapwm_val_t period, next_period, buf0, next_buf0, buf1, next_buf1;
  bapwm_val_t cnt, next_cnt;
  logic [2:0] irq_stat, next_irq_stat, irq_en, next_irq_en;
  logic wr_fire, wr_known;
  logic dwr0, dwr1;
  logic period_start;
  bapwm_val_t cmp0, cmp1;
  logic late0, late1;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction : merge

  function automatic logic known(input bapwm_addr_t a);
    return a inside {`BAPWM_OFF_CTRL, `BAPWM_OFF_PERIOD, `BAPWM_OFF_BUF0, `BAPWM_OFF_BUF1,
      `BAPWM_OFF_CMP0, `BAPWM_OFF_CMP1, `BAPWM_OFF_CNT, `BAPWM_OFF_IRQ_STAT,
      `BAPWM_OFF_IRQ_EN, `BAPWM_OFF_IRQ_CLR};
  endfunction : known

  assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
  assign S_AXI_WREADY = !w_held && !S_AXI_BVALID;
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  assign wr_fire = aw_held && w_held && !S_AXI_BVALID;
  assign wr_known = known(aw_addr);
  assign period_start = ctrl[`BAPWM_CTRL_RUN] && (cnt == 16'h0000);
  assign dwr0 = wr_fire && (aw_addr == `BAPWM_OFF_CMP0);
  assign dwr1 = wr_fire && (aw_addr == `BAPWM_OFF_CMP1);
  assign IRQ = |(irq_stat & irq_en);

  // Bus and register next values
  always_comb
  begin
    logic [31:0] wv;
    wv = 32'h0000_0000;
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = S_AXI_BVALID;
    next_bresp = S_AXI_BRESP;
    next_rvalid = S_AXI_RVALID;
    next_rdata = S_AXI_RDATA;
    next_rresp = S_AXI_RRESP;
    next_ctrl = ctrl;
    next_period = period;
    next_buf0 = buf0;
    next_buf1 = buf1;
    next_irq_en = irq_en;
    next_irq_stat = irq_stat;
    if (S_AXI_AWVALID && S_AXI_AWREADY)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY)
    begin
      next_w_held = 1'b1;
      next_w_data = S_AXI_WDATA;
      next_w_strb = S_AXI_WSTRB;
    end
    if (S_AXI_BVALID && S_AXI_BREADY)
      next_bvalid = 1'b0;
    if (wr_fire)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = wr_known ? BAPWM_RESP_OKAY : BAPWM_RESP_SLVERR;
      unique case (aw_addr)
        `BAPWM_OFF_CTRL:
        begin
          wv = merge({30'h0000_0000, ctrl}, w_data, w_strb);
          next_ctrl = wv[1:0];
        end
        `BAPWM_OFF_PERIOD:
        begin
          wv = merge({16'h0000, period}, w_data, w_strb);
          next_period = wv[15:0];
        end
        `BAPWM_OFF_BUF0:
        begin
          wv = merge({16'h0000, buf0}, w_data, w_strb);
          next_buf0 = wv[15:0];
        end
        `BAPWM_OFF_BUF1:
        begin
          wv = merge({16'h0000, buf1}, w_data, w_strb);
          next_buf1 = wv[15:0];
        end
        `BAPWM_OFF_IRQ_EN:
        begin
          wv = merge({29'h0000_0000, irq_en}, w_data, w_strb);
          next_irq_en = wv[2:0];
        end
        `BAPWM_OFF_IRQ_CLR:
          next_irq_stat = irq_stat & ~(w_data[2:0] & {3{w_strb[0]}});
        default:
          wv = 32'h0000_0000;
      endcase
    end
    // Events set after the clear so a coincident event wins
    if (period_start)
      next_irq_stat[`BAPWM_IRQ_PERIOD] = 1'b1;
    if (late0)
      next_irq_stat[`BAPWM_IRQ_LATE0] = 1'b1;
    if (late1)
      next_irq_stat[`BAPWM_IRQ_LATE1] = 1'b1;
    if (S_AXI_RVALID && S_AXI_RREADY)
      next_rvalid = 1'b0;
    if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      next_rvalid = 1'b1;
      next_rresp = known(S_AXI_ARADDR) ? BAPWM_RESP_OKAY : BAPWM_RESP_SLVERR;
      unique case (S_AXI_ARADDR)
        `BAPWM_OFF_CTRL: next_rdata = {30'h0000_0000, ctrl};
        `BAPWM_OFF_PERIOD: next_rdata = {16'h0000, period};
        `BAPWM_OFF_BUF0: next_rdata = {16'h0000, buf0};
        `BAPWM_OFF_BUF1: next_rdata = {16'h0000, buf1};
        `BAPWM_OFF_CMP0: next_rdata = {16'h0000, cmp0};
        `BAPWM_OFF_CMP1: next_rdata = {16'h0000, cmp1};
        `BAPWM_OFF_CNT: next_rdata = {16'h0000, cnt};
        `BAPWM_OFF_IRQ_STAT: next_rdata = {29'h0000_0000, irq_stat};
        `BAPWM_OFF_IRQ_EN: next_rdata = {29'h0000_0000, irq_en};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // Period counter: counts 0..period, wraps to 0 for each period start
  always_comb
  begin
    if (!ctrl[`BAPWM_CTRL_RUN])
      next_cnt = 16'h0000;
    else if (cnt >= period)
      next_cnt = 16'h0000;
    else
      next_cnt = cnt + 16'h0001;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= 2'b00;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= 2'b00;
      ctrl <= 2'b00;
      period <= `BAPWM_PERIOD_RST;
      buf0 <= `BAPWM_DUTY_RST;
      buf1 <= `BAPWM_DUTY_RST;
      irq_en <= 3'b000;
      irq_stat <= 3'b000;
      cnt <= 16'h0000;
    end
    else
    begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      S_AXI_BVALID <= next_bvalid;
      S_AXI_BRESP <= next_bresp;
      S_AXI_RVALID <= next_rvalid;
      S_AXI_RDATA <= next_rdata;
      S_AXI_RRESP <= next_rresp;
      ctrl <= next_ctrl;
      period <= next_period;
      buf0 <= next_buf0;
      buf1 <= next_buf1;
      irq_en <= next_irq_en;
      irq_stat <= next_irq_stat;
      cnt <= next_cnt;
    end
  end

  bapwm_channel u_ch0 (
    .CLK_SYS(CLK_SYS),
    .RST(RST),
    .cnt(cnt),
    .period_start(period_start),
    .run(ctrl[`BAPWM_CTRL_RUN]),
    .buf_mode(ctrl[`BAPWM_CTRL_BUFMODE]),
    .buf_val(buf0),
    .direct_wr(dwr0),
    .direct_val(w_data[15:0]),
    .compare(cmp0),
    .late_write(late0),
    .pwm(PWM_OUT_CH0)
  );

  bapwm_channel u_ch1 (
    .CLK_SYS(CLK_SYS),
    .RST(RST),
    .cnt(cnt),
    .period_start(period_start),
    .run(ctrl[`BAPWM_CTRL_RUN]),
    .buf_mode(ctrl[`BAPWM_CTRL_BUFMODE]),
    .buf_val(buf1),
    .direct_wr(dwr1),
    .direct_val(w_data[15:0]),
    .compare(cmp1),
    .late_write(late1),
    .pwm(PWM_OUT_CH1)
  );

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  property p_late_irq;
    (irq_en[`BAPWM_IRQ_LATE0] && late0) |=> IRQ;
  endproperty
  a_late_irq: assert property (p_late_irq) else $error("enabled late write raised no interrupt");
  property p_period_evt;
    period_start |=> irq_stat[`BAPWM_IRQ_PERIOD];
  endproperty
  a_period_evt: assert property (p_period_evt) else $error("period event lost");
  property p_bresp_hold;
    (S_AXI_BVALID && !S_AXI_BREADY) |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
  endproperty
  a_bresp_hold: assert property (p_bresp_hold) else $error("write response dropped");
  property p_rresp_hold;
    (S_AXI_RVALID && !S_AXI_RREADY) |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
  endproperty
  a_rresp_hold: assert property (p_rresp_hold) else $error("read data dropped");
  property p_cnt_wrap;
    (ctrl[`BAPWM_CTRL_RUN] && cnt >= period && $stable(ctrl)) |=> cnt == 16'h0000;
  endproperty
  a_cnt_wrap: assert property (p_cnt_wrap) else $error("counter did not wrap");
endmodule : bapwm_top

// file: bapwm_amp_model.sv
`timescale 1ns/1ps
module bapwm_amp_model (
  // Clock
  input wire logic CLK_SYS,
  // Amplifier inputs driven by the pins
  input wire logic PWM_OUT_CH0,
  input wire logic PWM_OUT_CH1,
  // Measurement window
  input wire logic clear,
  output int high0,
  output int high1
);
  // Integrates each pin like the amplifier input filter: counts high cycles
  always @(posedge CLK_SYS)
  begin
    high0 <= clear ? 0 : high0 + int'(PWM_OUT_CH0);
    high1 <= clear ? 0 : high1 + int'(PWM_OUT_CH1);
  end
endmodule : bapwm_amp_model

// file: buffered_audio_pwm_tb.sv
`timescale 1ns/1ps
`include "bapwm_defines.svh"
module buffered_audio_pwm_tb;
  import bapwm_pkg::*;
  typedef struct {logic [15:0] d0; logic [15:0] d1; int h0; int h1;} bapwm_row_t;
  logic clk_sys, rst, awvalid, wvalid, bready, arvalid, rready, amp_clr;
  bapwm_addr_t awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] resp;
  wire awready, wready, bvalid, arready, rvalid, pwm0, pwm1, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata_o;
  int high0, high1, mismatches, total_checks;
  bapwm_row_t rows [4] = '{'{16'h0000, 16'h0010, 0, 64}, '{16'h0005, 16'h0009, 20, 36},
                           '{16'h0010, 16'h0001, 64, 4}, '{16'h0008, 16'h0008, 32, 32}};
  bapwm_top dut (.CLK_SYS(clk_sys), .RST(rst), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_AWADDR(awaddr), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hF), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_ARADDR(araddr), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata_o), .S_AXI_RRESP(rresp), .PWM_OUT_CH0(pwm0),
    .PWM_OUT_CH1(pwm1), .IRQ(irq));
  bapwm_amp_model amp (.CLK_SYS(clk_sys), .PWM_OUT_CH0(pwm0), .PWM_OUT_CH1(pwm1), .clear(amp_clr),
    .high0(high0), .high1(high1));
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic final_report;
    if (mismatches == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  task automatic wr(input bapwm_addr_t a, input logic [31:0] d);
    @(posedge clk_sys);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    bready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input bapwm_addr_t a);
    @(posedge clk_sys);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (arready)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rdata = rdata_o;
    resp = rresp;
    rready <= 1'b0;
  endtask : rd
  // Settle, then count high cycles over 64 cycles: four whole periods of 16, or one of 64 at period 0x3F
  task automatic measure;
    repeat (40) @(posedge clk_sys);
    amp_clr <= 1'b1;
    @(posedge clk_sys);
    amp_clr <= 1'b0;
    repeat (64) @(posedge clk_sys);
    #1;
  endtask : measure
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, amp_clr} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    rst = 1'b1;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    wr(`BAPWM_OFF_PERIOD, 32'h0000_000F);
    wr(`BAPWM_OFF_CTRL, 32'h0000_0003);
    foreach (rows[i])
    begin
      wr(`BAPWM_OFF_BUF0, {16'h0000, rows[i].d0});
      wr(`BAPWM_OFF_BUF1, {16'h0000, rows[i].d1});
      measure();
      chk("ch0 high cycles", rows[i].h0, high0);
      chk("ch1 high cycles", rows[i].h1, high1);
    end
    // Buffer write mid-period leaves the active compare alone until the wrap
    wr(`BAPWM_OFF_PERIOD, 32'h0000_003F);
    do rd(`BAPWM_OFF_CNT); while (rdata[15:0] > 16'h001E);
    wr(`BAPWM_OFF_BUF0, 32'h0000_0021);
    rd(`BAPWM_OFF_CMP0);
    chk("cmp0 before wrap", 32'h0000_0008, rdata);
    repeat (70) @(posedge clk_sys);
    rd(`BAPWM_OFF_CMP0);
    chk("cmp0 after wrap", 32'h0000_0021, rdata);
    wr(`BAPWM_OFF_CMP0, 32'h0000_0005);
    rd(`BAPWM_OFF_CMP0);
    chk("cmp0 direct in buffer mode", 32'h0000_0021, rdata);
    // Unbuffered late write past the counter
    wr(`BAPWM_OFF_CTRL, 32'h0000_0001);
    wr(`BAPWM_OFF_CMP0, 32'h0000_000A);
    wr(`BAPWM_OFF_IRQ_EN, 32'h0000_0002);
    do rd(`BAPWM_OFF_CNT); while (rdata[15:0] < 16'h001E || rdata[15:0] > 16'h002D);
    wr(`BAPWM_OFF_CMP0, 32'h0000_0014);
    @(posedge clk_sys);
    #1;
    chk("ch0 pin after late write", 32'h0000_0001, pwm0);
    rd(`BAPWM_OFF_IRQ_STAT);
    chk("late flag", 32'h0000_0002, rdata & 32'h0000_0002);
    chk("irq raised", 32'h0000_0001, irq);
    wr(`BAPWM_OFF_IRQ_EN, 32'h0000_0000);
    chk("irq masked", 32'h0000_0000, irq);
    wr(`BAPWM_OFF_IRQ_EN, 32'h0000_0002);
    wr(`BAPWM_OFF_IRQ_CLR, 32'h0000_0002);
    chk("irq cleared", 32'h0000_0000, irq);
    // On-time writes: host waits for the period flag, one sample per period
    wr(`BAPWM_OFF_IRQ_CLR, 32'h0000_0007);
    do rd(`BAPWM_OFF_IRQ_STAT); while (rdata[`BAPWM_IRQ_PERIOD] !== 1'b1);
    wr(`BAPWM_OFF_CMP0, 32'h0000_0030);
    wr(`BAPWM_OFF_CMP1, 32'h0000_0030);
    rd(`BAPWM_OFF_IRQ_STAT);
    chk("late flags after on-time writes", 32'h0000_0000, rdata & 32'h0000_0006);
    measure();
    chk("ch0 unbuffered high cycles", 32'h0000_0030, high0);
    chk("ch1 unbuffered high cycles", 32'h0000_0030, high1);
    // Late write on channel one
    do rd(`BAPWM_OFF_CNT); while (rdata[15:0] < 16'h0020 || rdata[15:0] > 16'h002D);
    wr(`BAPWM_OFF_CMP1, 32'h0000_0010);
    @(posedge clk_sys);
    #1;
    chk("ch1 pin after late write", 32'h0000_0001, pwm1);
    rd(`BAPWM_OFF_IRQ_STAT);
    chk("late flags ch1", 32'h0000_0004, rdata & 32'h0000_0006);
    rd(12'h0FC);
    chk("unmapped resp", 32'h0000_0002, resp);
    chk("unmapped data", 32'h0000_0000, rdata);
    // Reset in mid-run restores the register defaults
    rst <= 1'b1;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    chk("pins after reset", 32'h0000_0000, {irq, pwm1, pwm0});
    rd(`BAPWM_OFF_PERIOD);
    chk("period reset", 32'h0000_00FF, rdata);
    rd(`BAPWM_OFF_CTRL);
    chk("ctrl reset", 32'h0000_0000, rdata);
    rd(`BAPWM_OFF_BUF1);
    chk("buf1 reset", 32'h0000_0000, rdata);
    rd(`BAPWM_OFF_CMP1);
    chk("cmp1 reset", 32'h0000_0000, rdata);
    rd(`BAPWM_OFF_IRQ_STAT);
    chk("irq status reset", 32'h0000_0000, rdata);
    final_report();
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    final_report();
  end
endmodule : buffered_audio_pwm_tb
